//--- core/wsc_link_unit.sv
`timescale 1ns/1ps
module wsc_link_unit
  import wsc_pkg::*;
#(
  parameter int NPOS = 64
)
(
  // Link table, bit 6 marks an empty position
  input wire wsc_link_t [NPOS-1:0] link_tab,
  // Schedule whose successor is wanted
  input wire logic [5:0] cur_sched,
  // Results
  output logic [NPOS-1:0] dup_err,
  output logic has_next,
  output logic [5:0] next_sched
);
  `include "wsc_cfg.svh"

  // Each used position compares against every other one
  for (genvar i = 0; i < NPOS; i++)
  begin : g_dup
    logic [NPOS-1:0] hit;
    for (genvar j = 0; j < NPOS; j++)
    begin : g_cmp
      assign hit[j] = (i != j) && !link_tab[j][`WSC_F_EMPTY] && (link_tab[j][5:0] == link_tab[i][5:0]);
    end
    assign dup_err[i] = !link_tab[i][`WSC_F_EMPTY] && (|hit);
  end

  // Successor lookup; an ambiguous schedule never links anywhere
  always_comb
  begin
    has_next = 1'b0;
    next_sched = 6'h00;
    for (int p = 0; p < NPOS - 1; p++)
    begin
      if (!link_tab[p][`WSC_F_EMPTY] && link_tab[p][5:0] == cur_sched && !dup_err[p]
          && !link_tab[p+1][`WSC_F_EMPTY])
      begin
        has_next = 1'b1;
        next_sched = link_tab[p+1][5:0];
      end
    end
  end
endmodule : wsc_link_unit

//--- core/wsc_seq.sv
// The implementer's own choices: strobed register access and the address map.
`timescale 1ns/1ps
module wsc_seq
  import wsc_pkg::*;
#(
  parameter int NSCHED = 64,
  parameter int NPOS = 64,
  parameter int NTIME = 9
)
(
  // Clock, reset, enable
  input wire logic mclk,
  input wire logic reset,
  input wire logic clk_en,
  // Line-cycle timebase pulse
  input wire logic line_tick,
  // Weld start and external binary schedule select
  input wire logic start_in,
  input wire logic [5:0] bin_sched_in,
  // Register port
  input wire logic [7:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata,
  // Weld outputs
  output logic weld_fire,
  output logic seq_busy,
  output logic [3:0] seq_phase,
  output logic [5:0] shown_sched
);
  `include "wsc_cfg.svh"

  // Register file state
  logic bin_en_ff, nxt_bin_en;
  logic prog_ff, nxt_prog;
  logic dirty_ff, nxt_dirty;
  logic [5:0] sel_ff, nxt_sel;
  logic [4:0] edit_ff, nxt_edit;
  logic [4:0] cfg_ff [NSCHED], nxt_cfg [NSCHED];
  logic [7:0] time_ff [NTIME], nxt_time [NTIME];
  wsc_link_t link_ff [NPOS], nxt_link [NPOS];
  logic [5:0] lidx_ff, nxt_lidx;
  logic [31:0] rdata_ff, nxt_rdata;
  // Sequencer state
  wsc_phase_e phase_ff, nxt_phase;
  logic [7:0] cnt_ff, nxt_cnt;
  logic [5:0] run_ff, nxt_run;
  logic [5:0] succ_ff, nxt_succ;
  logic succ_vld_ff, nxt_succ_vld;
  logic begun_ff, nxt_begun;
  logic [2:0] start_sync_ff, nxt_start_sync;

  // Link lookup
  wsc_link_t [NPOS-1:0] link_flat;
  logic [NPOS-1:0] dup_err;
  logic has_next;
  logic [5:0] next_sched;
  logic [5:0] active_sched;
  wsc_start_e run_start;
  wsc_mode_e run_mode;
  logic start_lvl, start_rise, link_en, time_hit;
  logic [3:0] time_idx;

  // True when the address equals one register offset
  function automatic logic hit(input logic [7:0] a, input logic [7:0] off);
    hit = (a == off);
  endfunction : hit

  // Duration register of a phase; idle has none
  function automatic logic [7:0] ph_time(input wsc_phase_e p, input logic [7:0] t [NTIME]);
    ph_time = (p == ph_idle) ? 8'h00 : t[4'(p) - 4'h1];
  endfunction : ph_time

  for (genvar k = 0; k < NPOS; k++)
  begin : g_flat
    assign link_flat[k] = link_ff[k];
  end

  wsc_link_unit #(.NPOS(NPOS)) u_link (
    .link_tab(link_flat),
    .cur_sched(run_ff),
    .dup_err(dup_err),
    .has_next(has_next),
    .next_sched(next_sched)
  );

  // Derived selection and run configuration
  assign active_sched = bin_en_ff ? bin_sched_in : sel_ff;
  assign run_start = wsc_start_e'(cfg_ff[run_ff][1:0]);
  assign run_mode = wsc_mode_e'(cfg_ff[run_ff][4:2]);
  assign link_en = !bin_en_ff && run_mode != wm_cont_seam && run_mode != wm_roll_spot;
  assign start_lvl = start_sync_ff[1];
  assign start_rise = start_sync_ff[1] && !start_sync_ff[2];
  assign time_hit = reg_addr >= `WSC_OFF_TIME && reg_addr <= `WSC_OFF_TIME_END && reg_addr[1:0] == 2'b00;
  assign time_idx = 4'((reg_addr - `WSC_OFF_TIME) >> 2);

  // Register writes, edits and readback
  always_comb
  begin
    nxt_bin_en = bin_en_ff;
    nxt_prog = prog_ff;
    nxt_dirty = dirty_ff;
    nxt_sel = sel_ff;
    nxt_edit = edit_ff;
    nxt_cfg = cfg_ff;
    nxt_time = time_ff;
    nxt_link = link_ff;
    nxt_lidx = lidx_ff;
    nxt_rdata = 32'h0000_0000;
    if (reg_wr)
    begin
      if (hit(reg_addr, `WSC_OFF_CTRL))
      begin
        nxt_bin_en = reg_wdata[`WSC_F_BIN];
      end
      else if (hit(reg_addr, `WSC_OFF_SEL))
      begin
        if (!dirty_ff)
        begin
          nxt_sel = reg_wdata[5:0];
          nxt_edit = cfg_ff[reg_wdata[5:0]];
        end
      end
      else if (hit(reg_addr, `WSC_OFF_EDIT))
      begin
        // Edits only land in program mode, so a running weld never sees a half-made setup
        if (prog_ff && reg_wdata[4:0] != edit_ff)
        begin
          nxt_edit = reg_wdata[4:0];
          nxt_dirty = 1'b1;
        end
      end
      else if (hit(reg_addr, `WSC_OFF_CMD))
      begin
        if (reg_wdata[`WSC_F_SAVE])
        begin
          nxt_prog = !prog_ff;
          if (prog_ff)
          begin
            nxt_cfg[sel_ff] = edit_ff;
            nxt_dirty = 1'b0;
          end
        end
        else if (reg_wdata[`WSC_F_DISCARD])
        begin
          nxt_edit = cfg_ff[sel_ff];
          nxt_dirty = 1'b0;
        end
      end
      else if (hit(reg_addr, `WSC_OFF_LIDX))
      begin
        if (reg_wdata[`WSC_F_STEP_UP])
        begin
          nxt_lidx = lidx_ff + 6'h01;
        end
        else if (reg_wdata[`WSC_F_STEP_DN])
        begin
          nxt_lidx = lidx_ff - 6'h01;
        end
        else
        begin
          nxt_lidx = reg_wdata[5:0];
        end
      end
      else if (hit(reg_addr, `WSC_OFF_LDAT))
      begin
        nxt_link[lidx_ff] = reg_wdata[6:0];
      end
      else if (time_hit)
      begin
        nxt_time[time_idx] = reg_wdata[7:0];
      end
    end
    if (reg_rd)
    begin
      if (hit(reg_addr, `WSC_OFF_CTRL))
      begin
        nxt_rdata = {31'h0, bin_en_ff};
      end
      else if (hit(reg_addr, `WSC_OFF_SEL))
      begin
        nxt_rdata = {26'h0, active_sched};
      end
      else if (hit(reg_addr, `WSC_OFF_EDIT))
      begin
        nxt_rdata = {27'h0, edit_ff};
      end
      else if (hit(reg_addr, `WSC_OFF_STAT))
      begin
        nxt_rdata = {16'h0, 2'h0, run_ff, |dup_err, prog_ff, dirty_ff, weld_fire, 4'(phase_ff)};
      end
      else if (hit(reg_addr, `WSC_OFF_LIDX))
      begin
        nxt_rdata = {26'h0, lidx_ff};
      end
      else if (hit(reg_addr, `WSC_OFF_LDAT))
      begin
        nxt_rdata = {24'h0, dup_err[lidx_ff], link_ff[lidx_ff]};
      end
      else if (time_hit)
      begin
        nxt_rdata = {24'h0, time_ff[time_idx]};
      end
    end
  end

  always_ff @(posedge mclk)
  begin
    if (reset)
    begin
      bin_en_ff <= 1'b0;
      prog_ff <= 1'b0;
      dirty_ff <= 1'b0;
      sel_ff <= 6'h00;
      edit_ff <= `WSC_CFG_RST;
      lidx_ff <= 6'h00;
      rdata_ff <= 32'h0000_0000;
      for (int i = 0; i < NSCHED; i++)
      begin
        cfg_ff[i] <= `WSC_CFG_RST;
      end
      for (int i = 0; i < NTIME; i++)
      begin
        time_ff[i] <= `WSC_TIME_RST;
      end
      for (int i = 0; i < NPOS; i++)
      begin
        link_ff[i] <= `WSC_LINK_RST;
      end
    end
    else if (clk_en)
    begin
      bin_en_ff <= nxt_bin_en;
      prog_ff <= nxt_prog;
      dirty_ff <= nxt_dirty;
      sel_ff <= nxt_sel;
      edit_ff <= nxt_edit;
      cfg_ff <= nxt_cfg;
      time_ff <= nxt_time;
      link_ff <= nxt_link;
      lidx_ff <= nxt_lidx;
      rdata_ff <= nxt_rdata;
    end
  end

  // Phase sequencer: a zero duration still costs one clock in that phase, except a zero off time in repeat mode, which is raised to WSC_OFF_MIN ticks
  always_comb
  begin
    logic done;
    logic released;
    done = (cnt_ff == 8'h00);
    released = !start_lvl;
    nxt_phase = phase_ff;
    nxt_cnt = cnt_ff;
    nxt_run = run_ff;
    nxt_succ = succ_ff;
    nxt_succ_vld = succ_vld_ff;
    nxt_begun = begun_ff;
    nxt_start_sync = {start_sync_ff[1:0], start_in};
    if (line_tick && !done)
    begin
      nxt_cnt = cnt_ff - 8'h01;
    end
    case (phase_ff)
      ph_idle:
      begin
        if (start_rise)
        begin
          nxt_run = succ_vld_ff ? succ_ff : active_sched;
          nxt_begun = 1'b0;
          nxt_phase = ph_sqd;
        end
      end
      ph_sqd:
      begin
        if (released)
        begin
          nxt_phase = ph_idle;
        end
        else if (done)
        begin
          nxt_phase = ph_sqz;
        end
      end
      ph_sqz, ph_up1, ph_co, ph_up2:
      begin
        if (released && (run_start == st_maintained
            || (run_start == st_latched && (phase_ff == ph_sqz || (time_ff[1] != 8'h00 && !begun_ff)))))
        begin
          nxt_phase = ph_idle;
        end
        else if (done)
        begin
          nxt_phase = wsc_phase_e'(4'(phase_ff) + 4'h1);
        end
      end
      ph_w1:
      begin
        if (released && run_start == st_maintained)
        begin
          nxt_phase = ph_idle;
        end
        else if (done)
        begin
          nxt_phase = ph_co;
        end
      end
      ph_w2:
      begin
        if (released && run_start == st_maintained)
        begin
          nxt_phase = ph_idle;
        end
        else if (done)
        begin
          // Unless start is maintained, the seam loop only checks start at the end of a pass, so a release finishes the pass
          if (start_lvl && (run_start == st_seam || run_mode == wm_cont_seam))
          begin
            nxt_phase = ph_co;
          end
          else
          begin
            nxt_phase = ph_hold;
          end
        end
      end
      ph_hold:
      begin
        if (released && run_start == st_maintained)
        begin
          nxt_phase = ph_idle;
        end
        else if (done)
        begin
          nxt_phase = ph_off;
        end
      end
      ph_off:
      begin
        if (done)
        begin
          nxt_phase = ph_idle;
          if (start_lvl && (run_mode == wm_repeat || run_mode == wm_roll_spot))
          begin
            nxt_phase = ph_sqz;
          end
          else if (run_mode == wm_chaining && link_en && has_next)
          begin
            nxt_run = next_sched;
            nxt_begun = 1'b0;
            nxt_phase = ph_sqd;
          end
          else if (run_mode == wm_successive && link_en && has_next)
          begin
            nxt_succ = next_sched;
            nxt_succ_vld = 1'b1;
          end
          else
          begin
            nxt_succ_vld = 1'b0;
          end
        end
      end
      default:
      begin
        nxt_phase = ph_idle;
      end
    endcase
    if (nxt_phase == ph_w1 || nxt_phase == ph_w2)
    begin
      nxt_begun = 1'b1;
    end
    if (nxt_phase != phase_ff)
    begin
      nxt_cnt = ph_time(nxt_phase, time_ff);
      if (nxt_phase == ph_off && run_mode == wm_repeat && nxt_cnt == 8'h00)
      begin
        nxt_cnt = `WSC_OFF_MIN;
      end
    end
  end

  always_ff @(posedge mclk)
  begin
    if (reset)
    begin
      phase_ff <= ph_idle;
      cnt_ff <= 8'h00;
      run_ff <= 6'h00;
      succ_ff <= 6'h00;
      succ_vld_ff <= 1'b0;
      begun_ff <= 1'b0;
      start_sync_ff <= 3'h0;
    end
    else if (clk_en)
    begin
      phase_ff <= nxt_phase;
      cnt_ff <= nxt_cnt;
      run_ff <= nxt_run;
      succ_ff <= nxt_succ;
      succ_vld_ff <= nxt_succ_vld;
      begun_ff <= nxt_begun;
      start_sync_ff <= nxt_start_sync;
    end
  end

  // Outputs; firing follows the phase register so an abort drops it at once
  assign weld_fire = phase_ff == ph_up1 || phase_ff == ph_w1 || phase_ff == ph_up2 || phase_ff == ph_w2;
  assign seq_busy = phase_ff != ph_idle;
  assign seq_phase = 4'(phase_ff);
  assign shown_sched = seq_busy ? run_ff : (succ_vld_ff ? succ_ff : active_sched);
  assign reg_rdata = rdata_ff;
endmodule : wsc_seq

//--- shared/wsc_cfg.svh
`ifndef WSC_CFG_SVH
`define WSC_CFG_SVH
// Register byte offsets
`define WSC_OFF_CTRL 8'h00
`define WSC_OFF_SEL 8'h04
`define WSC_OFF_EDIT 8'h08
`define WSC_OFF_CMD 8'h0c
`define WSC_OFF_STAT 8'h10
`define WSC_OFF_LIDX 8'h14
`define WSC_OFF_LDAT 8'h18
`define WSC_OFF_TIME 8'h20
`define WSC_OFF_TIME_END 8'h40
// Field positions
`define WSC_F_BIN 0
`define WSC_F_SAVE 0
`define WSC_F_DISCARD 1
`define WSC_F_STEP_UP 6
`define WSC_F_STEP_DN 7
`define WSC_F_EMPTY 6
`define WSC_F_DUP 7
// Reset values and limits
`define WSC_CFG_RST 5'h00
`define WSC_TIME_RST 8'h01
`define WSC_LINK_RST 7'h40
`define WSC_SCHED_MAX 6'h3f
`define WSC_OFF_MIN 8'h01
`endif

//--- shared/wsc_pkg.sv
package wsc_pkg;
  typedef enum logic [1:0] {st_pulsed, st_latched, st_maintained, st_seam} wsc_start_e;
  typedef enum logic [2:0] {wm_spot, wm_repeat, wm_successive, wm_chaining, wm_cont_seam, wm_roll_spot} wsc_mode_e;
  typedef enum logic [3:0] {ph_idle, ph_sqd, ph_sqz, ph_up1, ph_w1, ph_co, ph_up2, ph_w2, ph_hold, ph_off} wsc_phase_e;
  typedef logic [6:0] wsc_link_t;
endpackage : wsc_pkg

//--- verification/tb_wsc_seq.sv
`timescale 1ns/1ps
`include "wsc_cfg.svh"
module tb_wsc_seq;
  import wsc_pkg::*;
  // Bench signals
  logic mclk, reset, clk_en, line_tick, press, start_in, reg_wr, reg_rd, weld_fire, seq_busy, saw_off;
  logic [5:0] bin_sched_in, shown_sched;
  logic [7:0] reg_addr;
  logic [31:0] reg_wdata, reg_rdata, rd_val;
  logic [3:0] seq_phase;
  logic [1:0] tick_cnt;
  int n_errors, n_compared, n_fire, i;

  wsc_seq uut (.mclk(mclk), .reset(reset), .clk_en(clk_en), .line_tick(line_tick), .start_in(start_in),
    .bin_sched_in(bin_sched_in), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .weld_fire(weld_fire), .seq_busy(seq_busy), .seq_phase(seq_phase),
    .shown_sched(shown_sched));
  wsc_start_switch u_sw (.mclk(mclk), .press(press), .start_in(start_in));

  initial
  begin
    mclk = 1'b0;
    forever #2.5 mclk = ~mclk;
  end

  // Line tick every fourth clock, so phase times stay short
  always @(posedge mclk)
  begin
    tick_cnt <= tick_cnt + 2'h1;
    line_tick <= (tick_cnt == 2'h3);
  end

  // Observe mid-cycle, away from the launching edge
  always @(negedge mclk)
  begin
    if (weld_fire === 1'b1) n_fire++;
    if (seq_phase === 4'h9) saw_off = 1'b1;
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp)
    begin
      n_errors++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge mclk);
    reg_wr <= 1'b0;
    @(posedge mclk);
  endtask : wr

  // Data taken 1 ns after the edge, in the one cycle that it stands
  task automatic rd(input logic [7:0] a);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge mclk);
    reg_rd <= 1'b0;
    #1 rd_val = reg_rdata;
    @(posedge mclk);
  endtask : rd

  // Program mode, edit the selected schedule, save back into run mode
  task automatic set_cfg(input logic [31:0] v);
    wr(`WSC_OFF_CMD, 32'h1);
    wr(`WSC_OFF_EDIT, v);
    wr(`WSC_OFF_CMD, 32'h1);
  endtask : set_cfg

  task automatic wait_phase(input logic [3:0] p);
    int k;
    k = 0;
    @(negedge mclk);
    while (seq_phase !== p && k < 400)
    begin
      @(negedge mclk);
      k++;
    end
    chk({28'h0, seq_phase}, {28'h0, p});
    @(posedge mclk);
  endtask : wait_phase

  task automatic t_reset;
    rd(`WSC_OFF_STAT); chk(rd_val, 32'h0);
    rd(`WSC_OFF_EDIT); chk(rd_val, 32'h0);
    rd(`WSC_OFF_TIME); chk(rd_val, 32'h1);
    rd(`WSC_OFF_LDAT); chk(rd_val, 32'h40);
    rd(8'h1c); chk(rd_val, 32'h0);
    $display("test reset done");
  endtask : t_reset

  task automatic t_spot;
    for (i = 0; i < 9; i++) wr(8'(`WSC_OFF_TIME + 4 * i), 32'h0);
    n_fire = 0;
    saw_off = 1'b0;
    press <= 1'b1;
    wait_phase(4'h1);
    press <= 1'b0;
    wait_phase(4'h0);
    chk(32'(n_fire), 32'h4);
    chk({31'h0, saw_off}, 32'h1);
    $display("test spot done");
  endtask : t_spot

  task automatic t_edit;
    wr(`WSC_OFF_CMD, 32'h1);
    rd(`WSC_OFF_STAT); chk(rd_val & 32'h60, 32'h40);
    wr(`WSC_OFF_EDIT, 32'h2);
    wr(`WSC_OFF_SEL, 32'h5);
    rd(`WSC_OFF_SEL); chk(rd_val, 32'h0);
    rd(`WSC_OFF_STAT); chk(rd_val & 32'h60, 32'h60);
    wr(`WSC_OFF_CMD, 32'h2);
    rd(`WSC_OFF_EDIT); chk(rd_val, 32'h0);
    wr(`WSC_OFF_EDIT, 32'h2);
    wr(`WSC_OFF_CMD, 32'h1);
    rd(`WSC_OFF_STAT); chk(rd_val & 32'h60, 32'h0);
    rd(`WSC_OFF_EDIT); chk(rd_val, 32'h2);
    wr(`WSC_OFF_SEL, 32'h5);
    rd(`WSC_OFF_SEL); chk(rd_val, 32'h5);
    rd(`WSC_OFF_EDIT); chk(rd_val, 32'h0);
    wr(`WSC_OFF_SEL, 32'h0);
    rd(`WSC_OFF_EDIT); chk(rd_val, 32'h2);
    $display("test edit done");
  endtask : t_edit

  // Maintained start dropped in squeeze must abort before any firing
  task automatic t_maint;
    wr(8'(`WSC_OFF_TIME + 4), 32'h3);
    n_fire = 0;
    saw_off = 1'b0;
    press <= 1'b1;
    wait_phase(4'h2);
    press <= 1'b0;
    wait_phase(4'h0);
    chk(32'(n_fire), 32'h0);
    chk({31'h0, saw_off}, 32'h0);
    $display("test maintained done");
  endtask : t_maint

  task automatic t_link;
    wr(`WSC_OFF_LIDX, 32'h0);
    wr(`WSC_OFF_LIDX, 32'h80);
    wr(`WSC_OFF_LDAT, 32'h5);
    wr(`WSC_OFF_LIDX, 32'h40);
    wr(`WSC_OFF_LDAT, 32'h5);
    wr(`WSC_OFF_LIDX, 32'h80);
    rd(`WSC_OFF_LDAT); chk(rd_val, 32'h85);
    wr(`WSC_OFF_LIDX, 32'h1);
    rd(`WSC_OFF_LDAT); chk(rd_val, 32'h40);
    rd(`WSC_OFF_STAT); chk(rd_val & 32'h80, 32'h80);
    $display("test link done");
  endtask : t_link

  // Binary select takes the external number, local selection when off
  task automatic t_bin;
    bin_sched_in <= 6'h2a;
    wr(`WSC_OFF_CTRL, 32'h1);
    rd(`WSC_OFF_SEL); chk(rd_val, 32'h2a);
    chk({26'h0, shown_sched}, 32'h2a);
    wr(`WSC_OFF_CTRL, 32'h0);
    rd(`WSC_OFF_SEL); chk(rd_val, 32'h0);
    $display("test binary done");
  endtask : t_bin

  // Seam start loops the second weld while held, then finishes through hold and off
  task automatic t_seam;
    set_cfg(32'h3);
    saw_off = 1'b0;
    press <= 1'b1;
    wait_phase(4'h7);
    wait_phase(4'h5);
    press <= 1'b0;
    wait_phase(4'h8);
    wait_phase(4'h0);
    chk({31'h0, saw_off}, 32'h1);
    $display("test seam done");
  endtask : t_seam

  // Repeat: off lasts at least a tick even at zero, then squeeze again without squeeze delay
  task automatic t_repeat;
    set_cfg(32'h4);
    press <= 1'b1;
    wait_phase(4'h9);
    @(negedge mclk);
    chk({28'h0, seq_phase}, 32'h9);
    while (seq_phase === 4'h9) @(negedge mclk);
    chk({28'h0, seq_phase}, 32'h2);
    @(posedge mclk);
    press <= 1'b0;
    wait_phase(4'h0);
    $display("test repeat done");
  endtask : t_repeat

  // Chaining runs the linked schedule on one start, then shows the start schedule again
  task automatic t_chain;
    wr(`WSC_OFF_LIDX, 32'h1);
    wr(`WSC_OFF_LDAT, 32'h0);
    wr(`WSC_OFF_LIDX, 32'h2);
    wr(`WSC_OFF_LDAT, 32'h1);
    set_cfg(32'hc);
    press <= 1'b1;
    wait_phase(4'h1);
    wait_phase(4'h1);
    #1 chk({26'h0, shown_sched}, 32'h1);
    wait_phase(4'h0);
    press <= 1'b0;
    #1 chk({26'h0, shown_sched}, 32'h0);
    $display("test chain done");
  endtask : t_chain

  // Successive: each start fires one schedule, idles, then returns to the first
  task automatic t_succ;
    set_cfg(32'h8);
    press <= 1'b1;
    wait_phase(4'h1);
    wait_phase(4'h0);
    press <= 1'b0;
    #1 chk({26'h0, shown_sched}, 32'h1);
    repeat (4) @(posedge mclk);
    chk({28'h0, seq_phase}, 32'h0);
    press <= 1'b1;
    wait_phase(4'h1);
    #1 chk({26'h0, shown_sched}, 32'h1);
    wait_phase(4'h0);
    press <= 1'b0;
    #1 chk({26'h0, shown_sched}, 32'h0);
    $display("test successive done");
  endtask : t_succ

  task automatic stop_test;
    $display("compared=%0d errors=%0d", n_compared, n_errors);
    if (n_errors == 0 && n_compared > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask : stop_test

  initial
  begin
    #100000;
    n_errors++;
    stop_test();
  end

  initial
  begin
    reset = 1'b1;
    clk_en = 1'b1;
    line_tick = 1'b0;
    tick_cnt = 2'h0;
    press = 1'b0;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_addr = 8'h00;
    reg_wdata = 32'h0;
    bin_sched_in = 6'h00;
    n_errors = 0;
    n_compared = 0;
    n_fire = 0;
    saw_off = 1'b0;
    repeat (4) @(posedge mclk);
    reset <= 1'b0;
    @(posedge mclk);
    t_reset();
    t_spot();
    t_edit();
    t_maint();
    t_link();
    t_bin();
    t_seam();
    t_repeat();
    t_chain();
    t_succ();
    stop_test();
  end
endmodule : tb_wsc_seq

//--- verification/wsc_seq_sva.sv
`timescale 1ns/1ps
module wsc_seq_sva
(
  // Clock, reset and enable
  input wire logic mclk,
  input wire logic reset,
  input wire logic clk_en,
  // Start and register read
  input wire logic start_in,
  input wire logic reg_rd,
  input wire logic [31:0] reg_rdata,
  // Sequencer outputs
  input wire logic weld_fire,
  input wire logic seq_busy,
  input wire logic [3:0] seq_phase
);
  // One domain, so one clock and one reset for all
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (reset);

  // Read data only stands in the cycle after a read strobe
  a_rdata_idle_zero: assert property (!$past(reg_rd) && $past(clk_en) |-> reg_rdata == 32'h0)
    else $error("read data not zero outside read slot");
  // Firing only in upslope and weld phases
  a_fire_weld_phase: assert property (weld_fire == (seq_phase inside {4'h3, 4'h4, 4'h6, 4'h7}))
    else $error("weld firing disagrees with phase");
  a_busy_phase: assert property (seq_busy == (seq_phase != 4'h0))
    else $error("busy disagrees with phase");
  a_phase_legal: assert property (seq_phase <= 4'h9)
    else $error("illegal phase code");
  // Synchroniser delay bounds the start latency
  a_start_to_sqd: assert property (clk_en && !seq_busy && $rose(start_in) |-> ##[1:4] seq_phase == 4'h1)
    else $error("start not taken into squeeze delay");
  // Squeeze delay leads to squeeze or abort only
  a_sqd_next: assert property ($past(seq_phase) == 4'h1 && seq_phase != 4'h1 |-> seq_phase inside {4'h0, 4'h2})
    else $error("bad phase after squeeze delay");
  a_w2_next: assert property ($past(seq_phase) == 4'h7 && seq_phase != 4'h7 |-> seq_phase inside {4'h0, 4'h5, 4'h8})
    else $error("bad phase after second weld");
  a_off_next: assert property ($past(seq_phase) == 4'h9 && seq_phase != 4'h9 |-> seq_phase inside {4'h0, 4'h1, 4'h2})
    else $error("bad phase after off time");
endmodule : wsc_seq_sva

bind wsc_seq wsc_seq_sva u_sva (.mclk(mclk), .reset(reset), .clk_en(clk_en), .start_in(start_in),
  .reg_rd(reg_rd), .reg_rdata(reg_rdata), .weld_fire(weld_fire), .seq_busy(seq_busy), .seq_phase(seq_phase));

//--- verification/wsc_start_switch.sv
`timescale 1ns/1ps
module wsc_start_switch
(
  // Clock and operator command
  input wire logic mclk,
  input wire logic press,
  // Start level toward the sequencer
  output logic start_in
);
  logic nxt_start_ff;
  logic start_ff;
  // Switch holds start exactly as long as commanded; early release is a scenario choice
  always_comb nxt_start_ff = press;
  always_ff @(posedge mclk) start_ff <= nxt_start_ff;
  assign start_in = start_ff;
endmodule : wsc_start_switch
